// ===== inc/dlct_defs.vh
/*
 Register offsets, field positions, reset values and timing counts
 for the dual counter/timer block. Assumes inclusion by bare name.
*/
`ifndef DLCT_DEFS_VH
`define DLCT_DEFS_VH

// Byte addresses of the APB registers (one aligned word each)
`define DLCT_ADDR_CTRL 12'h000
`define DLCT_ADDR_MODE 12'h004
`define DLCT_ADDR_CLK 12'h008
`define DLCT_ADDR_IEN 12'h00C
`define DLCT_ADDR_T0L 12'h010
`define DLCT_ADDR_T0H 12'h014
`define DLCT_ADDR_T1L 12'h018
`define DLCT_ADDR_T1H 12'h01C
`define DLCT_ADDR_GPOL 12'h020

// Control register fields
`define DLCT_CTRL_TF1 7
`define DLCT_CTRL_TR1 6
`define DLCT_CTRL_TF0 5
`define DLCT_CTRL_TR0 4

// Mode register: per timer nibble {gate, ct, mode[1:0]}
`define DLCT_MODE_T1_LSB 4
`define DLCT_MODE_T0_LSB 0
`define DLCT_MODE_GATE 3
`define DLCT_MODE_CT 2

// Clock control fields
`define DLCT_CLK_T1M 4
`define DLCT_CLK_T0M 3

// Interrupt enable fields
`define DLCT_IEN_ET1 3
`define DLCT_IEN_ET0 1

// Operating modes
`define DLCT_MODE_13 2'h0
`define DLCT_MODE_16 2'h1
`define DLCT_MODE_8R 2'h2
`define DLCT_MODE_SPLIT 2'h3

// Prescale divisors selected by the clock scale field
`define DLCT_DIV_SCA0 12
`define DLCT_DIV_SCA1 4
`define DLCT_DIV_SCA2 48
`define DLCT_DIV_SCA3 8

`define DLCT_RESET_BYTE 8'h00
`define DLCT_PRESCALE_W 6

`endif

// ===== rtl/dlct_prescaler.v
/*
 Prescaler: one-cycle enable pulse at pclk divided by the ratio
 chosen by the clock scale field. Assumes a single clock domain.
*/
`timescale 1ns/1ps
`include "dlct_defs.vh"

module dlct_prescaler
(
    input wire pclk,
    input wire presetn,
    input wire [1:0] scale,
    output reg tick
);
    reg [`DLCT_PRESCALE_W-1:0] cnt;
    reg [`DLCT_PRESCALE_W-1:0] last;

    localparam [`DLCT_PRESCALE_W-1:0] last_sca0 = `DLCT_DIV_SCA0 - 1;
    localparam [`DLCT_PRESCALE_W-1:0] last_sca1 = `DLCT_DIV_SCA1 - 1;
    localparam [`DLCT_PRESCALE_W-1:0] last_sca2 = `DLCT_DIV_SCA2 - 1;
    localparam [`DLCT_PRESCALE_W-1:0] last_sca3 = `DLCT_DIV_SCA3 - 1;

    always @*
    begin
        case (scale)
            2'h0: last = last_sca0;
            2'h1: last = last_sca1;
            2'h2: last = last_sca2;
            default: last = last_sca3;
        endcase
    end

    // A scale change mid-period clips the period rather than waiting
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= {`DLCT_PRESCALE_W{1'b0}};
            tick <= 1'b0;
        end
        else if (cnt >= last)
        begin
            cnt <= {`DLCT_PRESCALE_W{1'b0}};
            tick <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// ===== rtl/dlct_edge_detect.v
/*
 Two-flop synchroniser and falling-edge detector for one event pin.
 Assumes the pin holds each level at least two pclk cycles.
*/
`timescale 1ns/1ps

module dlct_edge_detect
(
    input wire pclk,
    input wire presetn,
    input wire pin,
    output wire fall
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // One fall per two clocks at most is caught
    assign fall = s3 & ~s2;
endmodule

// ===== rtl/dlct_top.v
/*
 Dual counter/timer with APB register access.
 Assumes an APB master on pclk; event and gate pins synchronous.
*/
`timescale 1ns/1ps
`include "dlct_defs.vh"

module dlct_top
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire first_timer_event_pin,
    input wire second_timer_event_pin,
    input wire first_external_gate_input,
    input wire second_external_gate_input,
    output wire first_timer_irq,
    output wire second_timer_irq
);
    reg [7:0] timer_control_register;
    reg [7:0] timer_mode_register;
    reg [7:0] clock_control_register;
    reg [7:0] interrupt_enable_register;
    reg [7:0] gate_polarity;
    reg [7:0] first_timer_low_byte;
    reg [7:0] first_timer_high_byte;
    reg [7:0] second_timer_low_byte;
    reg [7:0] second_timer_high_byte;

    wire prescale_tick;
    wire fall0;
    wire fall1;
    wire wr;
    wire mapped;

    dlct_prescaler u_pre
    (
        .pclk(pclk),
        .presetn(presetn),
        .scale(clock_control_register[1:0]),
        .tick(prescale_tick)
    );

    dlct_edge_detect u_ev0
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin(first_timer_event_pin),
        .fall(fall0)
    );

    dlct_edge_detect u_ev1
    (
        .pclk(pclk),
        .presetn(presetn),
        .pin(second_timer_event_pin),
        .fall(fall1)
    );

    // Decode shared by write strobes and the mapped check
    function is_addr;
        input [11:0] a;
        input [11:0] target;
        begin
            is_addr = (a == target);
        end
    endfunction

    // Count tick for one timer from its own mode nibble and clock bit
    function tick_of;
        input [3:0] nib;
        input clk_sel;
        input ptick;
        input fall;
        begin
            if (nib[`DLCT_MODE_CT])
                tick_of = fall;
            else if (clk_sel)
                tick_of = 1'b1;
            else
                tick_of = ptick;
        end
    endfunction

    // Gating: run and (gate off or gate pin at configured level)
    function run_of;
        input tr;
        input gate;
        input pin;
        input pol;
        begin
            run_of = tr & (~gate | (pin == pol));
        end
    endfunction

    wire [3:0] nib0 = timer_mode_register[`DLCT_MODE_T0_LSB +: 4];
    wire [3:0] nib1 = timer_mode_register[`DLCT_MODE_T1_LSB +: 4];
    wire [1:0] mode0 = nib0[1:0];
    wire [1:0] mode1 = nib1[1:0];
    wire split = (mode0 == `DLCT_MODE_SPLIT);

    // Independent settings per timer
    wire tk0 = tick_of(nib0, clock_control_register[`DLCT_CLK_T0M],
                       prescale_tick, fall0);
    wire tk1 = tick_of(nib1, clock_control_register[`DLCT_CLK_T1M],
                       prescale_tick, fall1);
    // Split high half: timer only, clocked by first timer clock select
    wire tkh = clock_control_register[`DLCT_CLK_T0M] | prescale_tick;

    wire en0 = tk0 & run_of(timer_control_register[`DLCT_CTRL_TR0],
                            nib0[`DLCT_MODE_GATE],
                            first_external_gate_input, gate_polarity[0]);
    // Second timer stops entirely while the first is split
    wire en1 = tk1 & ~split & (mode1 != `DLCT_MODE_SPLIT) &
               run_of(timer_control_register[`DLCT_CTRL_TR1],
                      nib1[`DLCT_MODE_GATE],
                      second_external_gate_input, gate_polarity[1]);
    wire enh = split & tkh & timer_control_register[`DLCT_CTRL_TR1];

    // Next count for one timer; returns {overflow, high, low}
    function [16:0] step;
        input [1:0] mode;
        input [7:0] lo;
        input [7:0] hi;
        reg [13:0] c13;
        reg [16:0] c16;
        reg [8:0] c8;
        begin
            c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            c16 = {1'b0, hi, lo} + 17'h00001;
            c8 = {1'b0, lo} + 9'h001;
            case (mode)
                `DLCT_MODE_13:
                    step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                `DLCT_MODE_16:
                    step = c16;
                `DLCT_MODE_8R:
                    step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
                default:
                    step = {c8[8], hi, c8[7:0]};
            endcase
        end
    endfunction

    wire [16:0] nx0 = step(mode0, first_timer_low_byte,
                           first_timer_high_byte);
    wire [16:0] nx1 = step(mode1, second_timer_low_byte,
                           second_timer_high_byte);
    wire [8:0] nxh = {1'b0, first_timer_high_byte} + 9'h001;

    wire ovf0 = en0 & nx0[16];
    wire ovf1 = (en1 & nx1[16]) | (enh & nxh[8]);

    assign wr = psel & penable & pwrite;
    assign pready = 1'b1;
    // Unaligned offsets are refused like holes in the map
    assign mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                    (paddr[5] == 1'b0 || is_addr(paddr, `DLCT_ADDR_GPOL));
    assign pslverr = psel & penable & ~mapped;

    wire w_ctrl = wr & is_addr(paddr, `DLCT_ADDR_CTRL);
    wire w_t0l = wr & is_addr(paddr, `DLCT_ADDR_T0L);
    wire w_t0h = wr & is_addr(paddr, `DLCT_ADDR_T0H);
    wire w_t1l = wr & is_addr(paddr, `DLCT_ADDR_T1L);
    wire w_t1h = wr & is_addr(paddr, `DLCT_ADDR_T1H);

    // Config registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_mode_register <= `DLCT_RESET_BYTE;
            clock_control_register <= `DLCT_RESET_BYTE;
            interrupt_enable_register <= `DLCT_RESET_BYTE;
            gate_polarity <= `DLCT_RESET_BYTE;
        end
        else if (wr)
        begin
            if (is_addr(paddr, `DLCT_ADDR_MODE))
                timer_mode_register <= pwdata[7:0];
            if (is_addr(paddr, `DLCT_ADDR_CLK))
                clock_control_register <= pwdata[7:0];
            if (is_addr(paddr, `DLCT_ADDR_IEN))
                interrupt_enable_register <= pwdata[7:0];
            if (is_addr(paddr, `DLCT_ADDR_GPOL))
                gate_polarity <= pwdata[7:0];
        end
    end

    // Control: run bits plus flags; software write wins over set
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_control_register <= `DLCT_RESET_BYTE;
        else if (w_ctrl)
            timer_control_register <= pwdata[7:0];
        else
        begin
            if (ovf0)
                timer_control_register[`DLCT_CTRL_TF0] <= 1'b1;
            if (ovf1)
                timer_control_register[`DLCT_CTRL_TF1] <= 1'b1;
        end
    end

    // Counts; run bit never clears them
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_timer_low_byte <= `DLCT_RESET_BYTE;
            first_timer_high_byte <= `DLCT_RESET_BYTE;
            second_timer_low_byte <= `DLCT_RESET_BYTE;
            second_timer_high_byte <= `DLCT_RESET_BYTE;
        end
        else
        begin
            // Byte writes take effect at once, running or not
            if (w_t0l)
                first_timer_low_byte <= pwdata[7:0];
            else if (en0)
                first_timer_low_byte <= nx0[7:0];
            if (w_t0h)
                first_timer_high_byte <= pwdata[7:0];
            else if (enh)
                first_timer_high_byte <= nxh[7:0];
            else if (en0 && !split)
                first_timer_high_byte <= nx0[15:8];
            if (w_t1l)
                second_timer_low_byte <= pwdata[7:0];
            else if (en1)
                second_timer_low_byte <= nx1[7:0];
            if (w_t1h)
                second_timer_high_byte <= pwdata[7:0];
            else if (en1)
                second_timer_high_byte <= nx1[15:8];
        end
    end

    // Interrupt requests forwarded only when enabled
    assign first_timer_irq = timer_control_register[`DLCT_CTRL_TF0] &
        interrupt_enable_register[`DLCT_IEN_ET0];
    assign second_timer_irq = timer_control_register[`DLCT_CTRL_TF1] &
        interrupt_enable_register[`DLCT_IEN_ET1];

    // Read data registered in the setup phase, valid in access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `DLCT_ADDR_CTRL: prdata <= {24'h000000,
                                            timer_control_register};
                `DLCT_ADDR_MODE: prdata <= {24'h000000,
                                            timer_mode_register};
                `DLCT_ADDR_CLK: prdata <= {24'h000000,
                                           clock_control_register};
                `DLCT_ADDR_IEN: prdata <= {24'h000000,
                                           interrupt_enable_register};
                `DLCT_ADDR_T0L: prdata <= {24'h000000,
                                           first_timer_low_byte};
                `DLCT_ADDR_T0H: prdata <= {24'h000000,
                                           first_timer_high_byte};
                `DLCT_ADDR_T1L: prdata <= {24'h000000,
                                           second_timer_low_byte};
                `DLCT_ADDR_T1H: prdata <= {24'h000000,
                                           second_timer_high_byte};
                `DLCT_ADDR_GPOL: prdata <= {24'h000000, gate_polarity};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ===== tb/dlct_event_src.sv
/*
 Model of one external event source on a counter pin.
 Assumes pclk from the bench; the pin idles high between bursts.
*/
`timescale 1ns/1ps
module dlct_event_src
(
    input wire pclk,
    output reg pin
);
    initial pin = 1'b1;

    // Each level stands hold clocks, two at least
    task automatic pulse(input integer n, input integer hold);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1)
            begin
                repeat (hold) @(posedge pclk);
                pin <= 1'b0;
                repeat (hold) @(posedge pclk);
                pin <= 1'b1;
            end
        end
    endtask
endmodule

// ===== tb/dlct_top_sva.sv
/*
 Port-level assertions for the dual counter/timer.
 Assumes one clock domain and reset active low; bound to dlct_top.
*/
`timescale 1ns/1ps
`include "dlct_defs.vh"
module dlct_checker
(
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire first_timer_irq,
    input wire second_timer_irq
);
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire mapped = paddr <= `DLCT_ADDR_GPOL && paddr[1:0] == 2'h0;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_always: assert property (acc |-> pready)
        else $error("access without ready");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("error response on wrong address");
    a_unmapped_zero: assert property (rd_setup && !mapped
        |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (
        rd_setup |=> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_mask_first: assert property (
        wr && paddr == `DLCT_ADDR_IEN && !pwdata[`DLCT_IEN_ET0]
        |=> !first_timer_irq)
        else $error("first irq passed while disabled");
    a_mask_second: assert property (
        wr && paddr == `DLCT_ADDR_IEN && !pwdata[`DLCT_IEN_ET1]
        |=> !second_timer_irq)
        else $error("second irq passed while disabled");
    a_flag_wins: assert property (
        wr && paddr == `DLCT_ADDR_CTRL && !pwdata[`DLCT_CTRL_TF0]
        |=> !first_timer_irq)
        else $error("flag write did not clear first irq");
    a_hold_first: assert property (
        first_timer_irq && !wr |=> first_timer_irq)
        else $error("first irq dropped without a write");
    a_hold_second: assert property (
        second_timer_irq && !wr |=> second_timer_irq)
        else $error("second irq dropped without a write");
    a_read_flag: assert property (
        rd_setup && paddr == `DLCT_ADDR_CTRL && first_timer_irq
        |=> prdata[`DLCT_CTRL_TF0])
        else $error("control read lost first flag");
endmodule

bind dlct_top dlct_checker chk_u
(
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .first_timer_irq(first_timer_irq),
    .second_timer_irq(second_timer_irq)
);

// ===== tb/test_dual_legacy_counter_timer.sv
/*
 Self-checking bench for the dual counter/timer over APB.
 Assumes two event source models drive the event pins.
*/
`timescale 1ns/1ps
`include "dlct_defs.vh"
module test_dual_legacy_counter_timer;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic external_gate_enable;
    logic gate1;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire ev0;
    wire ev1;
    wire irq0;
    wire irq1;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] r;
    integer err_total = 0;
    integer checks_done = 0;
    integer seed = 31;
    integer i;
    integer n0;

    dlct_top dut_u
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .first_timer_event_pin(ev0),
        .second_timer_event_pin(ev1),
        .first_external_gate_input(external_gate_enable),
        .second_external_gate_input(gate1),
        .first_timer_irq(irq0),
        .second_timer_irq(irq1)
    );
    dlct_event_src ev0_u
    (
        .pclk(pclk),
        .pin(ev0)
    );
    dlct_event_src ev1_u
    (
        .pclk(pclk),
        .pin(ev1)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks_done++;
            if (got !== exp)
            begin
                err_total++;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e,
        input logic [31:0] m);
        begin
            exp_q.push_back(e);
            msk_q.push_back(m);
            apb(1'b0, a, 32'h0);
        end
    endtask

    task irq_is(input logic [1:0] e);
        begin
            @(negedge pclk);
            chk({30'h0, irq1, irq0}, {30'h0, e});
        end
    endtask

    // Falls are counted two edges after the pin is sampled
    task both(input integer a, input integer b);
        begin
            fork
                ev0_u.pulse(a, 2);
                ev1_u.pulse(b, 3);
            join
            repeat (4) @(posedge pclk);
        end
    endtask

    task end_of_test;
        begin
            $display("checks %0d errors %0d", checks_done, err_total);
            if (err_total == 0 && checks_done > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask

    always @(posedge pclk)
        if (psel && penable && pready && !pwrite && exp_q.size() > 0)
            chk(prdata & msk_q.pop_front(), exp_q.pop_front());

    always @(posedge pclk)
        if (psel && penable && paddr == 12'h024)
            chk({31'h0, pslverr}, 32'h1);

    initial
    begin
        #3000000;
        err_total++;
        end_of_test;
    end

    initial
    begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {external_gate_enable, gate1} = 2'h0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i <= 36; i = i + 4)
            rd(i[11:0], 32'h0, 32'hFFFFFFFF);
        apb(1'b1, 12'h024, 32'hFF);
        rd(12'h024, 32'h0, 32'hFFFFFFFF);
        for (i = 16; i < 32; i = i + 4)
        begin
            r = $random(seed);
            apb(1'b1, i[11:0], r);
            rd(i[11:0], r & 32'hFF, 32'hFFFFFFFF);
        end
        // Thirteen-bit rollover from 0x1FFC on the system clock
        apb(1'b1, `DLCT_ADDR_CLK, 32'h08);
        apb(1'b1, `DLCT_ADDR_T0H, 32'hFF);
        apb(1'b1, `DLCT_ADDR_T0L, 32'hFC);
        apb(1'b1, `DLCT_ADDR_IEN, 32'h02);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h10);
        for (i = 0; i < 40 && irq0 !== 1'b1; i = i + 1)
            @(posedge pclk);
        irq_is(2'h1);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h20);
        rd(`DLCT_ADDR_CTRL, 32'h20, 32'hFF);
        rd(`DLCT_ADDR_T0H, 32'h00, 32'hFF);
        apb(1'b1, `DLCT_ADDR_IEN, 32'h00);
        irq_is(2'h0);
        apb(1'b1, `DLCT_ADDR_IEN, 32'h0A);
        irq_is(2'h1);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h00);
        irq_is(2'h0);
        // Both timers count pin edges; preloads survive the start
        apb(1'b1, `DLCT_ADDR_MODE, 32'h44);
        apb(1'b1, `DLCT_ADDR_T0L, 32'hE0);
        apb(1'b1, `DLCT_ADDR_T1L, 32'h03);
        apb(1'b1, `DLCT_ADDR_T1H, 32'h00);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h50);
        n0 = 1 + {$random(seed)} % 8;
        both(n0, 5);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h00);
        rd(`DLCT_ADDR_T0L, n0, 32'h1F);
        rd(`DLCT_ADDR_T1L, 32'h08, 32'h1F);
        // Gated counting, one active low and one active high
        apb(1'b1, `DLCT_ADDR_GPOL, 32'h02);
        apb(1'b1, `DLCT_ADDR_MODE, 32'hCC);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h50);
        both(3, 3);
        external_gate_enable <= 1'b1;
        gate1 <= 1'b1;
        both(2, 2);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h00);
        rd(`DLCT_ADDR_T0L, n0 + 3, 32'h1F);
        rd(`DLCT_ADDR_T1L, 32'h0A, 32'h1F);
        // First timer 16-bit carry, second 8-bit reload
        apb(1'b1, `DLCT_ADDR_MODE, 32'h65);
        apb(1'b1, `DLCT_ADDR_T0L, 32'hFE);
        apb(1'b1, `DLCT_ADDR_T0H, 32'h00);
        apb(1'b1, `DLCT_ADDR_T1L, 32'hFE);
        apb(1'b1, `DLCT_ADDR_T1H, 32'h40);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h50);
        both(3, 3);
        rd(`DLCT_ADDR_CTRL, 32'hD0, 32'hF0);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h00);
        rd(`DLCT_ADDR_T0L, 32'h01, 32'hFF);
        rd(`DLCT_ADDR_T0H, 32'h01, 32'hFF);
        rd(`DLCT_ADDR_T1L, 32'h41, 32'hFF);
        rd(`DLCT_ADDR_T1H, 32'h40, 32'hFF);
        // Split: high half runs on the second run bit, sets its flag
        apb(1'b1, `DLCT_ADDR_MODE, 32'h07);
        apb(1'b1, `DLCT_ADDR_T0H, 32'hFE);
        apb(1'b1, `DLCT_ADDR_IEN, 32'h08);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h40);
        for (i = 0; i < 40 && irq1 !== 1'b1; i = i + 1)
            @(posedge pclk);
        irq_is(2'h2);
        apb(1'b1, `DLCT_ADDR_CTRL, 32'h00);
        irq_is(2'h0);
        @(posedge pclk);
        end_of_test;
    end
endmodule
